// *** rtl/jump_merge_pkg.sv ***
// Purpose: shared constants and carriers for the merge/jump execute block
// Assumes: 32-bit words, 32 general registers
// Notes: opcodes, field positions, carrier structs and flow states
package jump_merge_pkg;

    // ------------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------------
    localparam int OP_HI = 31;
    localparam int OP_LO = 26;
    localparam int SRC_HI = 25;
    localparam int SRC_LO = 21;
    localparam int TGT_HI = 20;
    localparam int TGT_LO = 16;
    localparam int TOP_HI = 15;
    localparam int TOP_LO = 11;
    localparam int BASE_HI = 10;
    localparam int BASE_LO = 6;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;
    localparam int INDEX_HI = 25;
    localparam int BARRIER_BIT = 10;
    localparam int REGION_LO = 28;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [5:0] OP_ZERO = 6'h00;
    localparam logic [5:0] OP_REGION_JUMP = 6'h02;
    localparam logic [5:0] OP_REGION_CALL = 6'h03;
    localparam logic [5:0] OP_THREE = 6'h1f;
    localparam logic [5:0] FN_MERGE = 6'h04;
    localparam logic [5:0] FN_INDIRECT_CALL = 6'h09;
    localparam logic [4:0] LINK_REG = 5'h1f;
    localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
    localparam logic [31:0] SLOT_OFFSET = 32'h0000_0004;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam int RELEASE_WITH_MERGE = 2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] pc;
        logic [31:0] src_val;
        logic [31:0] dst_val;
    } issue_t;

    typedef struct packed {
        logic wr_en;
        logic [4:0] wr_addr;
        logic [31:0] wr_data;
    } reg_write_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLOT = 2'b01,
        ST_CHECK = 2'b11
    } flow_state_t;

endpackage

// *** rtl/bitfield_merge_unit.sv ***
// Purpose: combinational bit-field merge datapath
// Assumes: base and top indices already decoded
// Notes: reports an illegal field when base exceeds top
`timescale 1ns/1ps
module bitfield_merge_unit
    import jump_merge_pkg::*;
(
    // operands
    input wire logic [31:0] old_val_in,
    input wire logic [31:0] src_val_in,
    input wire logic [4:0] top_in,
    input wire logic [4:0] base_in,
    // result
    output logic [31:0] merged_out,
    output logic bad_field_out
);

    logic [31:0] field_mask;
    logic [31:0] shifted_src;

    // ------------------------------------------------------------------
    // mask and merge
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < 32; i++)
        begin : g_mask
            assign field_mask[i] = (5'(i) >= base_in) && (5'(i) <= top_in);
        end
    endgenerate

    assign shifted_src = src_val_in << base_in;
    // old high bits, low source bits, old low bits  (see RQ2)
    assign merged_out = (old_val_in & ~field_mask) |
                        (shifted_src & field_mask);
    assign bad_field_out = base_in > top_in; // see RQ4

endmodule

// *** rtl/bitfield_insert_and_jumps.sv ***
// Purpose: execute the field merge, region jumps and indirect call
// Assumes: one instruction offered per issue_valid_in pulse
// Notes: jumps redirect the pc after the delay-slot instruction
`timescale 1ns/1ps
// Behaviour
// RQ1: decode merge opcode, top and base fields
// RQ2: merge low source bits into target field
// RQ3: before release 2 merge is reserved
// RQ4: base above top leaves target unchanged
// RQ5: region target low bits are index shifted
// RQ6: upper bits come from delay-slot address
// RQ7: delay slot executes before redirect
// RQ8: last-word jump lands in next region
// RQ9: region call links pc plus 8 to 31
// RQ10: indirect call links pc plus 8
// RQ11: indirect target bit 0 forced zero
// RQ12: compressed set loads select from bit 0
// RQ13: hint bit 10 requests hazard barrier
// RQ14: software keeps source and link distinct
// RQ15: plain set faults on low bits nonzero
// RQ16: compressed set faults on 10 pattern
// RQ17: software keeps jumps out of slots
module bitfield_insert_and_jumps
    import jump_merge_pkg::*;
#(
    parameter int ARCH_RELEASE = 2,
    parameter bit COMPRESSED_ISA = 1'b0
)
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // issue stream
    input wire logic issue_valid_in,
    input wire issue_t issue_in,
    // register file write
    output reg_write_t reg_write_out,
    // program counter control
    output logic redirect_out,
    output logic [31:0] redirect_pc_out,
    output logic instruction_set_select_out,
    output logic barrier_out,
    // exceptions
    output logic reserved_exc_out,
    output logic addr_err_out
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_merge(input logic [31:0] w);
        return w[OP_HI:OP_LO] == OP_THREE && w[FN_HI:FN_LO] == FN_MERGE;
    endfunction

    function automatic logic is_indirect(input logic [31:0] w);
        return w[OP_HI:OP_LO] == OP_ZERO &&
               w[FN_HI:FN_LO] == FN_INDIRECT_CALL;
    endfunction

    function automatic logic is_region(input logic [31:0] w);
        return w[OP_HI:OP_LO] == OP_REGION_JUMP ||
               w[OP_HI:OP_LO] == OP_REGION_CALL;
    endfunction

    logic [31:0] w;
    logic dec_merge, dec_ind, dec_reg, dec_call;
    logic [31:0] merged;
    logic bad_field;

    assign w = issue_in.word;
    assign dec_merge = issue_valid_in && is_merge(w); // see RQ1
    assign dec_ind = issue_valid_in && is_indirect(w);
    assign dec_reg = issue_valid_in && is_region(w);
    assign dec_call = w[OP_HI:OP_LO] == OP_REGION_CALL;

    bitfield_merge_unit bitfield_merge_unit_inst (
        .old_val_in(issue_in.dst_val),
        .src_val_in(issue_in.src_val),
        .top_in(w[TOP_HI:TOP_LO]), // see RQ1
        .base_in(w[BASE_HI:BASE_LO]),
        .merged_out(merged),
        .bad_field_out(bad_field)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    flow_state_t state_reg, state_next;
    logic [31:0] target_reg, target_next;
    logic isa_pend_reg, isa_pend_next;
    logic check_reg, check_next;
    reg_write_t wr_reg, wr_next;
    logic redir_reg, redir_next;
    logic [31:0] rpc_reg, rpc_next;
    logic isa_reg, isa_next;
    logic bar_reg, bar_next;
    logic resv_reg, resv_next;
    logic aerr_reg, aerr_next;
    logic [31:0] slot_pc;
    logic [31:0] link_pc;

    assign slot_pc = issue_in.pc + SLOT_OFFSET;
    assign link_pc = issue_in.pc + LINK_OFFSET;

    always_comb
    begin
        state_next = state_reg;
        target_next = target_reg;
        isa_pend_next = isa_pend_reg;
        check_next = check_reg;
        wr_next = '0;
        redir_next = 1'b0;
        rpc_next = rpc_reg;
        isa_next = isa_reg;
        bar_next = 1'b0;
        resv_next = 1'b0;
        aerr_next = 1'b0;
        unique case (state_reg)
            ST_RUN:
            begin
                if (dec_merge)
                begin
                    if (ARCH_RELEASE < RELEASE_WITH_MERGE)
                    begin
                        resv_next = 1'b1; // see RQ3
                    end
                    else if (!bad_field) // see RQ4
                    begin
                        wr_next.wr_en = 1'b1;
                        wr_next.wr_addr = w[TGT_HI:TGT_LO];
                        wr_next.wr_data = merged; // see RQ2
                    end
                end
                else if (dec_reg)
                begin
                    // slot address supplies the region bits  (see RQ6, RQ8)
                    target_next = {slot_pc[31:REGION_LO],
                                   w[INDEX_HI:0], 2'b00}; // see RQ5
                    isa_pend_next = isa_reg;
                    check_next = 1'b0;
                    state_next = ST_SLOT;
                    if (dec_call)
                    begin
                        wr_next.wr_en = 1'b1;
                        wr_next.wr_addr = LINK_REG;
                        wr_next.wr_data = link_pc; // see RQ9
                    end
                end
                else if (dec_ind)
                begin
                    // bit 0 never reaches the pc  (see RQ11)
                    target_next = {issue_in.src_val[31:1], 1'b0};
                    isa_pend_next = COMPRESSED_ISA ?
                        issue_in.src_val[0] : isa_reg; // see RQ12
                    // alignment is judged on the raw source value
                    check_next = COMPRESSED_ISA ?
                        (!issue_in.src_val[0] && issue_in.src_val[1]) :
                        (issue_in.src_val[1:0] != 2'b00); // see RQ15, RQ16
                    bar_next = ARCH_RELEASE >= RELEASE_WITH_MERGE &&
                               w[BARRIER_BIT]; // see RQ13
                    wr_next.wr_en = 1'b1;
                    wr_next.wr_addr = w[TOP_HI:TOP_LO];
                    wr_next.wr_data = link_pc; // see RQ10
                    state_next = ST_SLOT;
                end
            end
            ST_SLOT:
            begin
                // wait for the delay-slot instruction  (see RQ7, RQ17)
                if (issue_valid_in)
                begin
                    redir_next = 1'b1;
                    rpc_next = target_reg;
                    isa_next = isa_pend_reg;
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                // fault raised as the target is fetched  (see RQ15, RQ16)
                aerr_next = check_reg;
                check_next = 1'b0;
                state_next = ST_RUN;
            end
            default:
            begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= ST_RUN;
            target_reg <= '0;
            isa_pend_reg <= 1'b0;
            check_reg <= 1'b0;
            wr_reg <= '0;
            redir_reg <= 1'b0;
            rpc_reg <= RESET_PC;
            isa_reg <= 1'b0;
            bar_reg <= 1'b0;
            resv_reg <= 1'b0;
            aerr_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            target_reg <= target_next;
            isa_pend_reg <= isa_pend_next;
            check_reg <= check_next;
            wr_reg <= wr_next;
            redir_reg <= redir_next;
            rpc_reg <= rpc_next;
            isa_reg <= isa_next;
            bar_reg <= bar_next;
            resv_reg <= resv_next;
            aerr_reg <= aerr_next;
        end
    end

    assign reg_write_out = wr_reg;
    assign redirect_out = redir_reg;
    assign redirect_pc_out = rpc_reg;
    assign instruction_set_select_out = isa_reg;
    assign barrier_out = bar_reg;
    assign reserved_exc_out = resv_reg;
    assign addr_err_out = aerr_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    merge_write_a: assert property (@(posedge ref_clk_in) // see RQ2
        disable iff (sys_rst_in)
        dec_merge && state_reg == ST_RUN && !bad_field &&
        ARCH_RELEASE >= RELEASE_WITH_MERGE |=>
        reg_write_out.wr_en && reg_write_out.wr_data == $past(merged))
        else $error("merge result not written");

    reserved_merge_a: assert property (@(posedge ref_clk_in) // see RQ3
        disable iff (sys_rst_in)
        dec_merge && state_reg == ST_RUN |=>
        reserved_exc_out == (ARCH_RELEASE < RELEASE_WITH_MERGE))
        else $error("reserved merge handling wrong");

    bad_field_a: assert property (@(posedge ref_clk_in) // see RQ4
        disable iff (sys_rst_in)
        dec_merge && bad_field && state_reg == ST_RUN |=>
        !reg_write_out.wr_en && !addr_err_out)
        else $error("bad field wrote target");

    region_target_a: assert property (@(posedge ref_clk_in) // see RQ5
        disable iff (sys_rst_in)
        dec_reg && state_reg == ST_RUN ##1 issue_valid_in |=>
        redirect_out && redirect_pc_out[27:0] == {$past(w[25:0], 2), 2'b00})
        else $error("region low bits wrong");

    region_upper_a: assert property (@(posedge ref_clk_in) // see RQ6
        disable iff (sys_rst_in)
        dec_reg && state_reg == ST_RUN ##1 issue_valid_in |=>
        redirect_pc_out[31:28] == $past(slot_pc[31:28], 2))
        else $error("region upper bits wrong");

    slot_first_a: assert property (@(posedge ref_clk_in) // see RQ7
        disable iff (sys_rst_in)
        state_reg == ST_SLOT && !issue_valid_in |=> !redirect_out)
        else $error("redirect before delay slot");

    region_link_a: assert property (@(posedge ref_clk_in) // see RQ9
        disable iff (sys_rst_in)
        dec_reg && dec_call && state_reg == ST_RUN |=>
        reg_write_out.wr_addr == LINK_REG &&
        reg_write_out.wr_data == $past(issue_in.pc) + 32'h8)
        else $error("region call link wrong");

    indirect_bit0_a: assert property (@(posedge ref_clk_in) // see RQ11
        disable iff (sys_rst_in)
        redirect_out |-> !redirect_pc_out[0])
        else $error("indirect target bit 0 set");

    addr_fault_a: assert property (@(posedge ref_clk_in) // see RQ15
        disable iff (sys_rst_in)
        dec_ind && state_reg == ST_RUN && !COMPRESSED_ISA &&
        issue_in.src_val[1:0] != 2'b00 ##1 issue_valid_in |=>
        ##1 addr_err_out)
        else $error("misaligned indirect target not faulted");

endmodule

// *** tb/bitfield_insert_and_jumps_test.sv ***
// Purpose: self-checking bench for the merge and jump execute block
// Assumes: registered answers appear one cycle after each taken issue
// Notes: second instance is release 1 with the compressed set present
`timescale 1ns/1ps
module bitfield_insert_and_jumps_test
    import jump_merge_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic issue_valid = 1'b0;
    issue_t issue = '0;
    reg_write_t rw_a;
    reg_write_t rw_b;
    logic redir_a, redir_b, sel_a, sel_b, bar_a, bar_b;
    logic rsv_a, rsv_b, err_a, err_b;
    logic [31:0] rpc_a;
    logic [31:0] rpc_b;
    int n_fail = 0;
    int comparisons = 0;

    always #12.5 ref_clk_in = ~ref_clk_in;

    // ------------------------------------------------------------------
    // instances
    // ------------------------------------------------------------------
    bitfield_insert_and_jumps #(.ARCH_RELEASE(2), .COMPRESSED_ISA(1'b0))
    bitfield_insert_and_jumps_inst (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .issue_valid_in(issue_valid),
        .issue_in(issue), .reg_write_out(rw_a), .redirect_out(redir_a),
        .redirect_pc_out(rpc_a), .instruction_set_select_out(sel_a),
        .barrier_out(bar_a), .reserved_exc_out(rsv_a),
        .addr_err_out(err_a));
    bitfield_insert_and_jumps #(.ARCH_RELEASE(1), .COMPRESSED_ISA(1'b1))
    bitfield_insert_and_jumps_inst_b (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .issue_valid_in(issue_valid),
        .issue_in(issue), .reg_write_out(rw_b), .redirect_out(redir_b),
        .redirect_pc_out(rpc_b), .instruction_set_select_out(sel_b),
        .barrier_out(bar_b), .reserved_exc_out(rsv_b),
        .addr_err_out(err_b));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check32(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp,
                          input logic got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic put(input logic [31:0] w, input logic [31:0] p,
                       input logic [31:0] s, input logic [31:0] d);
        issue = '{word: w, pc: p, src_val: s, dst_val: d};
        issue_valid = 1'b1;
        @(negedge ref_clk_in);
    endtask

    task automatic idle;
        issue_valid = 1'b0;
        @(negedge ref_clk_in);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    task automatic t_reset;
        check1("reset wr_en", 1'b0, rw_a.wr_en);
        check1("reset redirect", 1'b0, redir_a);
        check32("reset target", RESET_PC, rpc_a);
        idle;
        $display("test reset done");
    endtask

    // back-to-back merges, full, narrow, single-bit and reversed fields
    task automatic t_merge;
        int top_t[5] = '{31, 7, 0, 31, 3};
        int base_t[5] = '{0, 4, 0, 31, 9};
        logic [32:0] m;
        logic [31:0] s, d, exp;
        d = 32'h0f0f_0f0f;
        for (int i = 0; i < 5; i++)
        begin
            s = 32'hdead_beef ^ i;
            put({OP_THREE, 5'h03, 5'h0b, 5'(top_t[i]), 5'(base_t[i]),
                 FN_MERGE}, 32'h100 + 4 * i, s, d);
            if (top_t[i] >= base_t[i])
            begin
                m = ((33'h1 << (top_t[i] - base_t[i] + 1)) - 1) << base_t[i];
                exp = (d & ~m[31:0]) | ((s << base_t[i]) & m[31:0]);
                check1("merge wr_en", 1'b1, rw_a.wr_en);
                check32("merge addr", 32'h0b, {27'h0, rw_a.wr_addr});
                check32("merge data", exp, rw_a.wr_data);
            end
            else
                check1("bad field wr_en", 1'b0, rw_a.wr_en);
            check1("merge reserved", 1'b0, rsv_a);
            check1("old reserved", 1'b1, rsv_b);
            check1("old merge wr_en", 1'b0, rw_b.wr_en);
        end
        idle;
        $display("test merge done");
    endtask

    // plain jump from the last word of a region, then call with full index
    task automatic t_region;
        logic [5:0] op_t[2] = '{OP_REGION_JUMP, OP_REGION_CALL};
        logic [31:0] pc_t[2] = '{32'h0fff_fffc, 32'h2345_6780};
        logic [25:0] ix_t[2] = '{26'h000_0123, 26'h3ff_ffff};
        logic [31:0] slot, tgt;
        for (int i = 0; i < 2; i++)
        begin
            slot = pc_t[i] + 32'h4;
            tgt = {slot[31:28], ix_t[i], 2'b00};
            put({op_t[i], ix_t[i]}, pc_t[i], 32'h0, 32'h0);
            check1("link wr_en", i == 1, rw_a.wr_en);
            if (i == 1)
            begin
                check32("link addr", 32'h1f, {27'h0, rw_a.wr_addr});
                check32("link data", pc_t[i] + 32'h8, rw_a.wr_data);
            end
            check1("early redirect", 1'b0, redir_a);
            check1("early redirect b", 1'b0, redir_b);
            if (i == 0)
            begin
                idle;
                check1("slot wait", 1'b0, redir_a);
            end
            put(32'h0, slot, 32'h0, 32'h0);
            check1("redirect", 1'b1, redir_a);
            check32("region target", tgt, rpc_a);
            check32("region target b", tgt, rpc_b);
            idle;
            check1("redirect pulse", 1'b0, redir_a);
            check1("region addr err", 1'b0, err_a);
        end
        $display("test region done");
    endtask

    // indirect calls with barrier hint, odd target and misaligned target
    task automatic t_indirect;
        logic [31:0] src_t[3] = '{32'h0000_1000, 32'h0000_2002,
                                 32'h0000_3001};
        logic hint_t[3] = '{1'b1, 1'b0, 1'b0};
        logic [31:0] s, p;
        for (int i = 0; i < 3; i++)
        begin
            s = src_t[i];
            p = 32'h0040_0000 + 16 * i;
            put({OP_ZERO, 5'h04, 5'h00, 5'h1a, hint_t[i], 4'h0,
                 FN_INDIRECT_CALL}, p, s, 32'h0);
            check1("call wr_en", 1'b1, rw_a.wr_en);
            check32("call addr", 32'h1a, {27'h0, rw_a.wr_addr});
            check32("call data", p + 32'h8, rw_a.wr_data);
            check1("barrier", hint_t[i], bar_a);
            check1("old barrier", 1'b0, bar_b);
            put(32'h0, p + 32'h4, 32'h0, 32'h0);
            check1("call redirect", 1'b1, redir_a);
            check32("call target", {s[31:1], 1'b0}, rpc_a);
            check32("call target b", {s[31:1], 1'b0}, rpc_b);
            check1("set select", s[0], sel_b);
            check1("plain select", 1'b0, sel_a);
            idle;
            check1("plain addr err", |s[1:0], err_a);
            check1("compressed addr err", ~s[0] & s[1], err_b);
        end
        $display("test indirect done");
    endtask

    // reset while waiting for a delay slot drops the pending jump
    task automatic t_midreset;
        put({OP_REGION_JUMP, 26'h000_0040}, 32'h0000_0200, 32'h0,
            32'h0);
        issue_valid = 1'b0;
        sys_rst_in = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        check1("midreset redirect", 1'b0, redir_a);
        check32("midreset target", RESET_PC, rpc_a);
        put(32'h0, 32'h0000_0204, 32'h0, 32'h0);
        check1("stale redirect", 1'b0, redir_a);
        check1("stale redirect b", 1'b0, redir_b);
        idle;
        check1("stale addr err", 1'b0, err_a);
        $display("test midreset done");
    endtask

    // ------------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (16) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        t_reset;
        t_merge;
        t_region;
        t_indirect;
        t_midreset;
        end_of_test;
    end

    initial
    begin
        repeat (1000) @(posedge ref_clk_in);
        n_fail++;
        $display("watchdog expired");
        end_of_test;
    end
endmodule
